// ---- hw/fmsp_pkg.sv ----
// constants and types shared by the four mode serial port
package fmsp_pkg;

	// ==========================================================
	// register addresses and reset values
	localparam logic [7:0] CTRL_ADDR  = 8'h98;
	localparam logic [7:0] BUF_ADDR   = 8'h99;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] BUF_RESET  = 8'h00;

	// ==========================================================
	// control register bit positions
	localparam int unsigned CTRL_MODE_HI_FE = 7;
	localparam int unsigned CTRL_MODE_LO    = 6;
	localparam int unsigned CTRL_MP_CMP     = 5;
	localparam int unsigned CTRL_RX_EN      = 4;
	localparam int unsigned CTRL_TX_NINTH   = 3;
	localparam int unsigned CTRL_RX_NINTH   = 2;
	localparam int unsigned CTRL_TX_DONE    = 1;
	localparam int unsigned CTRL_RX_FULL    = 0;

	// ==========================================================
	// bit timing: 16 oversample ticks per async bit
	localparam logic [3:0] OVS_LAST  = 4'hf;
	localparam logic [3:0] OVS_MID   = 4'h7;
	localparam logic [3:0] FRAME_10  = 4'ha;
	localparam logic [3:0] FRAME_11  = 4'hb;
	localparam logic [3:0] DATA_8    = 4'h8;
	localparam logic [3:0] DATA_9    = 4'h9;
	// shift mode phase lengths minus one (low phase, high phase)
	localparam logic [1:0] M0_DIV6_LO = 2'h2;
	localparam logic [1:0] M0_DIV6_HI = 2'h2;
	localparam logic [1:0] M0_DIV3_LO = 2'h1;
	localparam logic [1:0] M0_DIV3_HI = 2'h0;
	localparam logic [1:0] M0_DIV4_LO = 2'h1;
	localparam logic [1:0] M0_DIV4_HI = 2'h1;
	localparam logic [1:0] M0_DIV2_LO = 2'h0;
	localparam logic [1:0] M0_DIV2_HI = 2'h0;

	// ==========================================================
	// modes and states
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_UART8 = 2'b01,
		MODE_UART9 = 2'b10,
		MODE_UART9_VAR = 2'b11
	} fmsp_mode_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} fmsp_rx_t;

	typedef enum logic [1:0] {
		M0_IDLE = 2'b00,
		M0_TX   = 2'b01,
		M0_RX   = 2'b10
	} fmsp_m0_t;

endpackage

// ---- hw/fmsp_uart.sv ----
// four mode serial port: register access, shift mode engine, async transmitter and receiver
`timescale 1ns/1ps

// What this block does
// (RL1) transmitter and receiver run concurrently
// (RL2) receive while previous byte unread; overrun drops one
// (RL3) buffer write loads transmit, read returns receive
// (RL4) shift mode: eight bits LSB first, clock out
// (RL5) shift rate sixth/third, quarter/half, or timer 1
// (RL6) mode 1: start, eight data, stop
// (RL7) mode 1 received stop bit into ninth field
// (RL8) mode 1 rate from timer 1 or 2
// (RL9) modes 2/3: eleven bits, ninth from field
// (RL10) mode 2 received ninth stored, stop ignored
// (RL11) mode 2 rate sixteenth or thirty-second of clock
// (RL12) mode 3 equals mode 2, timer rate
// (RL13) buffer write starts transmission in every mode
// (RL14) shift mode receive when not full, enabled
// (RL15) async receive on start bit when enabled
// (RL16) interrupt on receive full and transmit done
// (RL17) control at 98h, bit writable, resets zero
// (RL18) framing error set on bad stop, software clears
// (RL19) bit 7 shows error or mode by select
// (RL20) shift data changes only while clock low
module fmsp_uart (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	// special function register port
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic       sfr_rd_i,
	input  wire logic       sfr_bit_wr_i,
	input  wire logic [2:0] sfr_bit_sel_i,
	input  wire logic       sfr_bit_val_i,
	output logic      [7:0] sfr_rdata_o,
	// rate selection from the rest of the chip
	input  wire logic       error_access_select_i,
	input  wire logic       fast_timing_i,
	input  wire logic       mode0_slow_i,
	input  wire logic       mode0_timer1_i,
	input  wire logic       mode2_fast_i,
	input  wire logic       tx_timer2_i,
	input  wire logic       rx_timer2_i,
	input  wire logic       timer1_ovf_i,
	input  wire logic       timer2_ovf_i,
	// serial pins
	input  wire logic       rxd_i,
	output logic            rxd_o,
	output logic            rxd_oe_o,
	output logic            txd_o,
	// interrupt request
	output logic            serial_irq_o
);

	// ==========================================================
	// control register fields
	logic       mode_select_hi;
	logic       mode_select_lo;
	logic       multiproc_compare_enable;
	logic       rx_enable;
	logic       tx_ninth_bit;
	logic       rx_ninth_bit;
	logic       tx_done_flag;
	logic       rx_full_flag;
	logic       framing_error_flag;
	logic [7:0] rx_buf;

	fmsp_pkg::fmsp_mode_t mode;
	logic                 ninth_mode;
	logic [7:0]           ctl_we;
	logic [7:0]           ctl_wd;
	logic [7:0]           ctl_rd;
	logic                 buf_wr;

	assign mode       = fmsp_pkg::fmsp_mode_t'({mode_select_hi, mode_select_lo});
	assign ninth_mode = mode_select_hi;
	assign buf_wr     = sfr_wr_i && (sfr_addr_i == fmsp_pkg::BUF_ADDR); // [RL3]

	// byte write replaces all bits, a bit write only the selected one [RL17]
	always_comb begin
		ctl_we = 8'h00;
		ctl_wd = sfr_wdata_i;
		if (sfr_wr_i && sfr_addr_i == fmsp_pkg::CTRL_ADDR) begin
			ctl_we = 8'hff;
		end else if (sfr_bit_wr_i) begin
			ctl_we = 8'h01 << sfr_bit_sel_i;
			ctl_wd = {8{sfr_bit_val_i}};
		end
	end

	assign ctl_rd = {error_access_select_i ? framing_error_flag : mode_select_hi, // [RL19]
		mode_select_lo, multiproc_compare_enable, rx_enable,
		tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_full_flag};

	// ==========================================================
	// pin synchroniser and rate ticks
	logic rxd_meta;
	logic rxd_s;
	logic rxd_d;
	logic m2_half;
	logic tx_tick;
	logic rx_tick;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rxd_meta <= 1'b1;
			rxd_s    <= 1'b1;
			rxd_d    <= 1'b1;
			m2_half  <= 1'b0;
		end else begin
			rxd_meta <= rxd_i;
			rxd_s    <= rxd_meta;
			rxd_d    <= rxd_s;
			m2_half  <= ~m2_half;
		end
	end

	// mode 2 bit is 16 or 32 clocks; modes 1/3 bit is 16 timer overflows
	assign tx_tick = (mode == fmsp_pkg::MODE_UART9) ? (mode2_fast_i | m2_half) :   // [RL11]
		(tx_timer2_i ? timer2_ovf_i : timer1_ovf_i);                               // [RL8] [RL12]
	assign rx_tick = (mode == fmsp_pkg::MODE_UART9) ? (mode2_fast_i | m2_half) :
		(rx_timer2_i ? timer2_ovf_i : timer1_ovf_i);

	// ==========================================================
	// shift mode engine (mode 0)
	fmsp_pkg::fmsp_m0_t m0_state;
	logic [1:0]         m0_cnt;
	logic               m0_hi;
	logic [3:0]         m0_bits;
	logic [7:0]         m0_sh;
	logic [1:0]         m0_last;
	logic               m0_step;
	logic               m0_phase_end;
	logic               m0_done;

	always_comb begin
		if (mode0_timer1_i) begin
			m0_last = 2'h0;
		end else if (fast_timing_i) begin
			m0_last = mode0_slow_i ? (m0_hi ? fmsp_pkg::M0_DIV4_HI : fmsp_pkg::M0_DIV4_LO)
				: (m0_hi ? fmsp_pkg::M0_DIV2_HI : fmsp_pkg::M0_DIV2_LO);
		end else begin
			m0_last = mode0_slow_i ? (m0_hi ? fmsp_pkg::M0_DIV6_HI : fmsp_pkg::M0_DIV6_LO)
				: (m0_hi ? fmsp_pkg::M0_DIV3_HI : fmsp_pkg::M0_DIV3_LO);
		end
	end

	assign m0_step      = mode0_timer1_i ? timer1_ovf_i : 1'b1;                       // [RL5]
	assign m0_phase_end = (m0_state != fmsp_pkg::M0_IDLE) && m0_step && (m0_cnt == m0_last);
	assign m0_done      = m0_phase_end && m0_hi && (m0_bits == fmsp_pkg::DATA_8 - 4'h1);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			m0_state <= fmsp_pkg::M0_IDLE;
			m0_cnt   <= 2'h0;
			m0_hi    <= 1'b0;
			m0_bits  <= 4'h0;
			m0_sh    <= 8'h00;
		end else if (mode != fmsp_pkg::MODE_SHIFT) begin
			m0_state <= fmsp_pkg::M0_IDLE;
		end else if (buf_wr) begin
			m0_state <= fmsp_pkg::M0_TX;                                            // [RL13]
			m0_sh    <= sfr_wdata_i;
			m0_cnt   <= 2'h0;
			m0_hi    <= 1'b0;
			m0_bits  <= 4'h0;
		end else if (m0_state == fmsp_pkg::M0_IDLE) begin
			if (rx_enable && !rx_full_flag) begin
				m0_state <= fmsp_pkg::M0_RX;                                        // [RL14]
				m0_cnt   <= 2'h0;
				m0_hi    <= 1'b0;
				m0_bits  <= 4'h0;
			end
		end else if (m0_step) begin
			m0_cnt <= m0_phase_end ? 2'h0 : m0_cnt + 2'h1;
			if (m0_phase_end) begin
				m0_hi <= ~m0_hi;
				// sample late in the high phase: the pin synchroniser costs two
				// clocks, so the remote's bit must have settled two clocks before the end of the high phase
				if (m0_hi && m0_state == fmsp_pkg::M0_RX) begin
					m0_sh <= {rxd_s, m0_sh[7:1]};                                    // [RL4]
				end
				if (m0_hi) begin
					// next bit goes out as the clock falls [RL20]
					if (m0_state == fmsp_pkg::M0_TX) begin
						m0_sh <= {1'b1, m0_sh[7:1]};
					end
					m0_bits <= m0_bits + 4'h1;
					if (m0_done) begin
						m0_state <= fmsp_pkg::M0_IDLE;
					end
				end
			end
		end
	end

	// ==========================================================
	// async transmitter (modes 1-3)
	logic        tx_busy;
	logic [10:0] tx_sh;
	logic [3:0]  tx_bits;
	logic [3:0]  tx_sub;
	logic        tx_end;

	assign tx_end = tx_busy && tx_tick && tx_sub == fmsp_pkg::OVS_LAST && tx_bits == 4'h1;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_busy <= 1'b0;
			tx_sh   <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_sub  <= 4'h0;
		end else if (buf_wr && mode != fmsp_pkg::MODE_SHIFT) begin
			tx_busy <= 1'b1;                                                        // [RL13]
			tx_sub  <= 4'h0;
			tx_bits <= ninth_mode ? fmsp_pkg::FRAME_11 : fmsp_pkg::FRAME_10;
			tx_sh   <= ninth_mode ? {1'b1, tx_ninth_bit, sfr_wdata_i, 1'b0}          // [RL9]
				: {2'b11, sfr_wdata_i, 1'b0};                                       // [RL6]
		end else if (mode == fmsp_pkg::MODE_SHIFT) begin
			tx_busy <= 1'b0;
		end else if (tx_busy && tx_tick) begin
			tx_sub <= tx_sub + 4'h1;
			if (tx_sub == fmsp_pkg::OVS_LAST) begin
				tx_sh   <= {1'b1, tx_sh[10:1]};
				tx_bits <= tx_bits - 4'h1;
				tx_busy <= !tx_end;
			end
		end
	end

	// ==========================================================
	// async receiver (modes 1-3)
	fmsp_pkg::fmsp_rx_t rx_state;
	logic [3:0]         rx_sub;
	logic [3:0]         rx_bits;
	logic [8:0]         rx_sh;
	logic               rx_done;
	logic               rx_stop_bit;
	logic [7:0]         rx_data;
	logic               rx_ninth;
	logic               rx_accept;

	assign rx_done     = rx_state == fmsp_pkg::RX_STOP && rx_tick && rx_sub == fmsp_pkg::OVS_LAST;
	assign rx_stop_bit = rxd_s;
	assign rx_data     = ninth_mode ? rx_sh[7:0] : rx_sh[8:1];
	assign rx_ninth    = ninth_mode ? rx_sh[8] : rx_stop_bit;                        // [RL7] [RL10]
	// a frame finishing while the buffer is still full is dropped [RL2]
	assign rx_accept   = rx_done && !rx_full_flag && (!multiproc_compare_enable || rx_ninth);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_state <= fmsp_pkg::RX_IDLE;
			rx_sub   <= 4'h0;
			rx_bits  <= 4'h0;
			rx_sh    <= 9'h000;
		end else if (mode == fmsp_pkg::MODE_SHIFT) begin
			rx_state <= fmsp_pkg::RX_IDLE;
		end else begin
			unique case (rx_state)
				fmsp_pkg::RX_IDLE: begin
					if (rx_enable && rxd_d && !rxd_s) begin                         // [RL15] [RL1]
						rx_state <= fmsp_pkg::RX_START;
						rx_sub   <= 4'h0;
					end
				end
				fmsp_pkg::RX_START: begin
					if (rx_tick) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == fmsp_pkg::OVS_MID) begin
							// a glitch shorter than half a bit is not a start
							rx_state <= rxd_s ? fmsp_pkg::RX_IDLE : fmsp_pkg::RX_DATA;
							rx_sub   <= 4'h0;
							rx_bits  <= 4'h0;
						end
					end
				end
				fmsp_pkg::RX_DATA: begin
					if (rx_tick) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_sub == fmsp_pkg::OVS_LAST) begin
							rx_sh   <= {rxd_s, rx_sh[8:1]};
							rx_bits <= rx_bits + 4'h1;
							if (rx_bits == (ninth_mode ? fmsp_pkg::DATA_9 : fmsp_pkg::DATA_8)
								- 4'h1) begin
								rx_state <= fmsp_pkg::RX_STOP;
							end
						end
					end
				end
				fmsp_pkg::RX_STOP: begin
					if (rx_tick) begin
						rx_sub <= rx_sub + 4'h1;
						if (rx_done) begin
							rx_state <= fmsp_pkg::RX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ==========================================================
	// control register, receive buffer; hardware sets win over software clears
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			{mode_select_hi, mode_select_lo, multiproc_compare_enable, rx_enable,
				tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_full_flag} <= fmsp_pkg::CTRL_RESET; // [RL17]
			framing_error_flag <= 1'b0;
			rx_buf             <= fmsp_pkg::BUF_RESET;
		end else begin
			if (ctl_we[fmsp_pkg::CTRL_MODE_HI_FE] && !error_access_select_i) begin
				mode_select_hi <= ctl_wd[fmsp_pkg::CTRL_MODE_HI_FE];
			end
			if (ctl_we[fmsp_pkg::CTRL_MODE_LO]) begin
				mode_select_lo <= ctl_wd[fmsp_pkg::CTRL_MODE_LO];
			end
			if (ctl_we[fmsp_pkg::CTRL_MP_CMP]) begin
				multiproc_compare_enable <= ctl_wd[fmsp_pkg::CTRL_MP_CMP];
			end
			if (ctl_we[fmsp_pkg::CTRL_RX_EN]) begin
				rx_enable <= ctl_wd[fmsp_pkg::CTRL_RX_EN];
			end
			if (ctl_we[fmsp_pkg::CTRL_TX_NINTH]) begin
				tx_ninth_bit <= ctl_wd[fmsp_pkg::CTRL_TX_NINTH];
			end
			if (rx_accept) begin
				rx_ninth_bit <= rx_ninth;
			end else if (ctl_we[fmsp_pkg::CTRL_RX_NINTH]) begin
				rx_ninth_bit <= ctl_wd[fmsp_pkg::CTRL_RX_NINTH];
			end
			if (tx_end || (m0_done && m0_state == fmsp_pkg::M0_TX)) begin
				tx_done_flag <= 1'b1;
			end else if (ctl_we[fmsp_pkg::CTRL_TX_DONE]) begin
				tx_done_flag <= ctl_wd[fmsp_pkg::CTRL_TX_DONE];
			end
			if (rx_accept || (m0_done && m0_state == fmsp_pkg::M0_RX)) begin
				rx_full_flag <= 1'b1;
				rx_buf       <= rx_accept ? rx_data : {rxd_s, m0_sh[7:1]};
			end else if (ctl_we[fmsp_pkg::CTRL_RX_FULL]) begin
				rx_full_flag <= ctl_wd[fmsp_pkg::CTRL_RX_FULL];
			end
			if (rx_done && !rx_stop_bit) begin
				framing_error_flag <= 1'b1;                                         // [RL18]
			end else if (ctl_we[fmsp_pkg::CTRL_MODE_HI_FE] && error_access_select_i) begin
				framing_error_flag <= ctl_wd[fmsp_pkg::CTRL_MODE_HI_FE];
			end
		end
	end

	// ==========================================================
	// registered outputs
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			sfr_rdata_o  <= 8'h00;
			txd_o        <= 1'b1;
			rxd_o        <= 1'b1;
			rxd_oe_o     <= 1'b0;
			serial_irq_o <= 1'b0;
		end else begin
			if (sfr_rd_i) begin
				sfr_rdata_o <= (sfr_addr_i == fmsp_pkg::CTRL_ADDR) ? ctl_rd :
					(sfr_addr_i == fmsp_pkg::BUF_ADDR) ? rx_buf : 8'h00;            // [RL3]
			end
			txd_o <= (mode == fmsp_pkg::MODE_SHIFT) ?
				(m0_state == fmsp_pkg::M0_IDLE || m0_hi) : tx_sh[0];                // [RL4]
			rxd_o        <= (m0_state == fmsp_pkg::M0_TX) ? m0_sh[0] : 1'b1;
			rxd_oe_o     <= (m0_state == fmsp_pkg::M0_TX);
			serial_irq_o <= rx_full_flag | tx_done_flag;                             // [RL16]
		end
	end

	// ==========================================================
	// assertions
	duplex_rx_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL1]
		(tx_busy && rx_state == fmsp_pkg::RX_IDLE && rx_enable && rxd_d && !rxd_s
			&& mode != fmsp_pkg::MODE_SHIFT) |=> rx_state == fmsp_pkg::RX_START)
		else $error("receiver blocked by transmitter");
	overrun_keep_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL2]
		(rx_done && rx_full_flag) |=> $stable(rx_buf))
		else $error("unread byte overwritten");
	buf_load_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL3]
		(buf_wr && mode != fmsp_pkg::MODE_SHIFT) |=> tx_busy && tx_sh[8:1] == $past(sfr_wdata_i))
		else $error("buffer write did not load transmitter");
	shift_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL4]
		(m0_state == fmsp_pkg::M0_TX) |=> rxd_oe_o)
		else $error("shift mode transmit not driving data pin");
	stop_high_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL6]
		(tx_busy && tx_bits == 4'h1) |-> tx_sh[0])
		else $error("stop bit not high");
	stop_store_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL7]
		(rx_accept && mode == fmsp_pkg::MODE_UART8) |=> rx_ninth_bit == $past(rxd_s))
		else $error("stop bit not stored");
	m0_rx_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL14]
		(mode == fmsp_pkg::MODE_SHIFT && m0_state == fmsp_pkg::M0_IDLE && rx_enable
			&& !rx_full_flag && !buf_wr) |=> m0_state == fmsp_pkg::M0_RX)
		else $error("shift mode reception not started");
	rx_disabled_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL15]
		(rx_state == fmsp_pkg::RX_IDLE && !rx_enable) |=> rx_state == fmsp_pkg::RX_IDLE)
		else $error("reception started while disabled");
	irq_raise_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL16]
		(rx_full_flag || tx_done_flag) |=> serial_irq_o)
		else $error("interrupt not raised");
	fe_sticky_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL18]
		(framing_error_flag && !ctl_we[fmsp_pkg::CTRL_MODE_HI_FE]) |=> framing_error_flag)
		else $error("framing error cleared without write");
	data_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i) // [RL20]
		(rxd_oe_o && $past(rxd_oe_o) && $changed(rxd_o)) |-> !txd_o)
		else $error("shift data changed while clock high");

	rx_frame_c: cover property (@(posedge core_clk_i) disable iff (rst_i) rx_accept);
	m0_tx_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		m0_done && m0_state == fmsp_pkg::M0_TX);
	overrun_c: cover property (@(posedge core_clk_i) disable iff (rst_i)
		rx_done && rx_full_flag);

endmodule

// ---- verif/fmsp_remote.sv ----
// remote partner: async transceiver and shift register facing the serial port
`timescale 1ns/1ps
module fmsp_remote (
	// clock
	input  wire logic core_clk_i,
	// serial lines
	input  wire logic ser_in_i,
	input  wire logic data_line_i,
	output logic      drv_o
);
	initial drv_o = 1'b1;

	// ==========================================================
	// bounded search for a level change on the device output
	task automatic edge_to(input logic lvl);
		logic prev;
		prev = ser_in_i;
		for (int n = 0; n < 400 && !(prev === ~lvl && ser_in_i === lvl); n++) begin
			prev = ser_in_i;
			@(posedge core_clk_i);
		end
	endtask

	// ==========================================================
	// async frames: low start bit, data lsb first, then stop
	task automatic send(input logic [8:0] d, input int nb, input logic stop, input int bc);
		drv_o <= 1'b0;
		repeat (bc) @(posedge core_clk_i);
		for (int i = 0; i < nb; i++) begin
			drv_o <= d[i];
			repeat (bc) @(posedge core_clk_i);
		end
		drv_o <= stop;
		repeat (bc) @(posedge core_clk_i);
		drv_o <= 1'b1;
	endtask

	// samples mid bit; a missing start leaves idle ones, which never match
	task automatic recv(input int nb, input int bc, output logic [8:0] d, output logic stop);
		d = '0;
		edge_to(1'b0);
		repeat (bc / 2) @(posedge core_clk_i);
		for (int i = 0; i < nb; i++) begin
			repeat (bc) @(posedge core_clk_i);
			d[i] = ser_in_i;
		end
		repeat (bc) @(posedge core_clk_i);
		stop = ser_in_i;
	endtask

	// ==========================================================
	// shift register: data taken at each rising shift clock
	task automatic shift_in(output logic [7:0] d, output int per);
		realtime t0;
		t0 = 0;
		d = 'x;
		for (int i = 0; i < 8; i++) begin
			edge_to(1'b1);
			d[i] = data_line_i;
			per = int'(($realtime - t0) / 4.0);
			t0 = $realtime;
		end
	endtask

	// next bit presented once the device has clocked the previous one in
	task automatic shift_out(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			drv_o <= d[i];
			edge_to(1'b1);
		end
		drv_o <= ~d[7];
	endtask
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the four mode serial port and its remote partner
`timescale 1ns/1ps
module tb;
	logic       core_clk_i, rst_i, sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o;
	logic [2:0] sfr_bit_sel_i;
	logic       esel, fast_t, m0_slow, m0_t1, m2_fast, tx_t2, t1_ovf, t2_ovf;
	logic       rx_t2;
	logic       rxd_o, rxd_oe_o, txd_o, serial_irq_o, drv, rx_line;
	int         n_mismatch;
	int         comparisons;

	assign rx_line = rxd_oe_o ? rxd_o : drv;

	fmsp_uart dut_u (
		.core_clk_i, .rst_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
		.sfr_bit_wr_i, .sfr_bit_sel_i, .sfr_bit_val_i, .sfr_rdata_o,
		.error_access_select_i(esel), .fast_timing_i(fast_t), .mode0_slow_i(m0_slow),
		.mode0_timer1_i(m0_t1), .mode2_fast_i(m2_fast), .tx_timer2_i(tx_t2),
		.rx_timer2_i(rx_t2), .timer1_ovf_i(t1_ovf), .timer2_ovf_i(t2_ovf),
		.rxd_i(rx_line), .rxd_o, .rxd_oe_o, .txd_o, .serial_irq_o
	);
	fmsp_remote u_remote (.core_clk_i, .ser_in_i(txd_o), .data_line_i(rx_line), .drv_o(drv));

	initial begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end

	// overflow every second cycle: 32 clocks per async bit
	always @(posedge core_clk_i) begin
		t1_ovf <= ~t1_ovf;
		t2_ovf <= ~t2_ovf;
	end

	// ==========================================================
	// shared tasks
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sfr_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic bwr(input logic [2:0] s, input logic v);
		sfr_bit_sel_i <= s;
		sfr_bit_val_i <= v;
		sfr_bit_wr_i <= 1'b1;
		@(posedge core_clk_i);
		sfr_bit_wr_i <= 1'b0;
		@(posedge core_clk_i);
	endtask

	// read data is held, so one spare edge costs nothing and hides latency doubt
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge core_clk_i);
		sfr_rd_i <= 1'b0;
		wait_cyc(2);
		d = sfr_rdata_o;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		rd(a, r);
		check(r, exp);
	endtask

	task automatic results();
		$display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic test_regs();
		rdchk(8'h98, 8'h00);
		rdchk(8'h5a, 8'h00);
		check(serial_irq_o, 1'b0);
		bwr(3'h5, 1'b1);
		bwr(3'h3, 1'b1);
		rdchk(8'h98, 8'h28);
		$display("regs done");
	endtask

	task automatic test_mode2_tx();
		logic [8:0] d;
		logic       stop;
		for (int k = 0; k < 2; k++) begin
			m2_fast <= k[0];
			wr(8'h98, k[0] ? 8'h88 : 8'h80);
			wr(8'h99, 8'ha5 ^ 8'(k));
			u_remote.recv(9, k[0] ? 16 : 32, d, stop);
			check(d, {k[0], 8'ha5 ^ 8'(k)});
			check(stop, 1'b1);
			wait_cyc(40);
			rdchk(8'h98, k[0] ? 8'h8a : 8'h82);
			check(serial_irq_o, 1'b1);
		end
		rdchk(8'h99, 8'h00);
		$display("mode 2 tx done");
	endtask

	task automatic test_mode1_rx();
		logic [7:0] r;
		wr(8'h98, 8'h40);
		u_remote.send(9'h03c, 8, 1'b1, 32);
		wait_cyc(40);
		rdchk(8'h98, 8'h40);
		wr(8'h98, 8'h50);
		u_remote.send(9'h03c, 8, 1'b1, 32);
		wait_cyc(40);
		rdchk(8'h98, 8'h55);
		check(serial_irq_o, 1'b1);
		u_remote.send(9'h0e1, 8, 1'b1, 32);
		wait_cyc(40);
		rdchk(8'h99, 8'h3c);
		wr(8'h98, 8'h50);
		u_remote.send(9'h0c3, 8, 1'b0, 32);
		wait_cyc(40);
		esel <= 1'b1;
		rd(8'h98, r);
		check(r & 8'hfc, 8'hd0);
		esel <= 1'b0;
		rd(8'h98, r);
		check(r & 8'hfc, 8'h50);
		wr(8'h98, 8'h50);
		u_remote.send(9'h0c3, 8, 1'b1, 32);
		wait_cyc(40);
		esel <= 1'b1;
		rdchk(8'h98, 8'hd5);
		bwr(3'h7, 1'b0);
		rdchk(8'h98, 8'h55);
		esel <= 1'b0;
		$display("mode 1 rx done");
	endtask

	task automatic test_mode3_duplex();
		logic [8:0] d;
		logic       stop;
		tx_t2 <= 1'b1;
		rx_t2 <= 1'b1;
		wr(8'h98, 8'hd0);
		wr(8'h99, 8'h69);
		fork
			u_remote.send(9'h196, 9, 1'b1, 32);
			u_remote.recv(9, 32, d, stop);
		join
		check(d, 9'h069);
		wait_cyc(40);
		rdchk(8'h99, 8'h96);
		rdchk(8'h98, 8'hd7);
		rx_t2 <= 1'b0;
		$display("mode 3 duplex done");
	endtask

	task automatic test_mode0();
		logic [7:0] d;
		int         per;
		int         exp_per [5] = '{6, 3, 4, 2, 4};
		for (int k = 0; k < 5; k++) begin
			fast_t <= k[1];
			m0_slow <= ~k[0];
			m0_t1 <= (k == 4);
			wr(8'h98, 8'h00);
			wr(8'h99, 8'h96 ^ 8'(k));
			u_remote.shift_in(d, per);
			check(d, 8'h96 ^ 8'(k));
			check(9'(per), 9'(exp_per[k]));
			wait_cyc(10);
			rdchk(8'h98, 8'h02);
		end
		fast_t <= 1'b1;
		m0_slow <= 1'b1;
		m0_t1 <= 1'b0;
		wr(8'h98, 8'h10);
		u_remote.shift_out(8'hc5);
		wait_cyc(10);
		rdchk(8'h99, 8'hc5);
		rdchk(8'h98, 8'h11);
		$display("mode 0 done");
	endtask

	// ==========================================================
	// main sequence and hang guard
	initial begin
		{rst_i, sfr_addr_i, sfr_wdata_i, sfr_bit_sel_i} = {1'b1, 19'h0};
		{sfr_wr_i, sfr_rd_i, sfr_bit_wr_i, sfr_bit_val_i} = 4'h0;
		{esel, fast_t, m0_slow, m0_t1, m2_fast, tx_t2, t1_ovf, t2_ovf} = 8'h00;
		rx_t2 = 1'b0;
		n_mismatch = 0;
		comparisons = 0;
		wait_cyc(2);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		test_regs();
		test_mode2_tx();
		test_mode1_rx();
		test_mode3_duplex();
		test_mode0();
		results();
	end

	initial begin
		wait_cyc(60000);
		n_mismatch++;
		$display("[FAIL] t=%0t run did not finish", $time);
		results();
	end
endmodule
